/* src/tvio_pkg.sv */
// Package for the TV-tuning MCU general-purpose I/O ports block.
// Assumes a single 40 MHz clock domain; used by src/tvio_ports.sv and the bench.
`default_nettype none
package tvio_pkg;
    // ========================================================
    // Port geometry
    localparam int PA_W = 8;                 // First port width
    localparam int PB_W = 8;                 // Second port bit span (bits 3 and 7 absent)
    localparam int PC_W = 8;                 // Third port width
    // Second port implemented lines (bits 3 and 7 absent)
    localparam logic [7:0] PB_MASK     = 8'h77;
    // First port open-drain lines, no pull-up
    localparam logic [7:0] PA_OD_MASK  = 8'hF0;
    // Third port lines lacking pull-up
    localparam logic [7:0] PC_NOPU_MASK = 8'hF0;
    // ========================================================
    // Third port bit positions of shared functions
    localparam int PC_SCL_BIT = 0;           // Serial clock line
    localparam int PC_SDA_BIT = 1;           // Serial data line
    localparam int PC_SEN_BIT = 3;           // Serial enable line
    localparam int PC_PWR_BIT = 4;           // Power interrupt input
    localparam int PC_IR_BIT  = 6;           // Infrared interrupt input
    // ========================================================
    // Reset values: all lines input, no pull-up, data zero
    localparam logic [7:0] DIR_RST  = 8'h00;
    localparam logic [7:0] PU_RST   = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Run-state machine
    typedef enum logic [1:0] {
        TVIO_RESET,
        TVIO_RUN,
        TVIO_PROG
    } tvio_mode_t;
endpackage
`default_nettype wire

/* src/tvio_ports.sv */
// Three general-purpose I/O ports with pin sharing, reset and test-pin handling.
// Assumes pads resolve out/oe/pull signals; pin inputs are asynchronous.
// How it works
// - First port: eight lines, per-line direction, pull-up
// - Second port: six lines, bits 3 and 7 absent
// - Third port: eight lines, configurable like others
// - First port upper nibble open-drain, no pull-up
// - Third port open-drain; upper nibble no pull-up
// - Third lines 0,1,3 AND with serial signals
// - Third lines 4,6 feed edge interrupt latches
// - Hold reset; restart program on release
// - Oscillator disabled while reset held low
// - Test pin high at reset enters programming
`timescale 1ns/10ps
`default_nettype none
module tvio_ports (
    input  wire logic       ref_clk_i,       // System clock, 40 MHz
    input  wire logic       rst_i,           // Async reset, active high
    input  wire logic       clk_en_i,        // Freezes state when low
    input  wire logic       reset_n_pin_i,   // External reset pin, active low
    input  wire logic       test_pin_i,      // Test pin, high = programming level
    input  wire logic [7:0] pa_dir_i,        // First port direction, 1 = output
    input  wire logic [7:0] pa_pu_i,         // First port pull-up select
    input  wire logic [7:0] pa_data_i,       // First port output data
    input  wire logic [7:0] pb_dir_i,        // Second port direction
    input  wire logic [7:0] pb_pu_i,         // Second port pull-up select
    input  wire logic [7:0] pb_data_i,       // Second port output data
    input  wire logic [7:0] pc_dir_i,        // Third port direction
    input  wire logic [7:0] pc_pu_i,         // Third port pull-up select
    input  wire logic [7:0] pc_data_i,       // Third port output data
    input  wire logic       spi_scl_i,       // Serial clock from serial unit
    input  wire logic       spi_sda_i,       // Serial data from serial unit
    input  wire logic       serial_enable_signal_i, // Serial enable
    input  wire logic       pwr_rise_i,      // Power latch edge: 1 rising
    input  wire logic       ir_rise_i,       // Infrared latch edge: 1 rising
    input  wire logic       pwr_clr_i,       // Clear power latch
    input  wire logic       ir_clr_i,        // Clear infrared latch
    input  wire logic [7:0] first_port_lines_i,  // First port pin levels
    input  wire logic [7:0] second_port_lines_i, // Second port pin levels
    input  wire logic [7:0] third_port_lines_i,  // Third port pin levels
    output logic      [7:0] first_port_lines_o,  // First port pin out value
    output logic      [7:0] first_port_lines_oe_o, // First port drive enable
    output logic      [7:0] first_port_pu_o,     // First port pull-up on
    output logic      [7:0] second_port_lines_o, // Second port pin out value
    output logic      [7:0] second_port_lines_oe_o, // Second port drive enable
    output logic      [7:0] second_port_pu_o,    // Second port pull-up on
    output logic      [7:0] third_port_lines_o,  // Third port pin out value
    output logic      [7:0] third_port_lines_oe_o, // Third port drive enable
    output logic      [7:0] third_port_pu_o,     // Third port pull-up on
    output logic      [7:0] pa_in_o,         // First port sampled levels
    output logic      [7:0] pb_in_o,         // Second port sampled levels
    output logic      [7:0] pc_in_o,         // Third port sampled levels
    output logic            power_interrupt_input_o,    // Power latch flag
    output logic            infrared_interrupt_input_o, // Infrared latch flag
    output logic            core_reset_o,    // Core held in reset
    output logic            restart_o,       // Pulse: restart from program start
    output logic            osc_en_o,        // Crystal oscillator enable
    output logic            prog_mode_o      // Memory programming mode
);
    // ========================================================
    // State
    typedef struct packed {
        logic [7:0] pa_s1;                   // First sync stage, first port
        logic [7:0] pb_s1;                   // First sync stage, second port
        logic [7:0] pc_s1;                   // First sync stage, third port
        logic [2:0] ctl_s1;                  // First stage: rst pin, test, spare
        logic [7:0] pa_in;                   // Second sync stage
        logic [7:0] pb_in;                   // Second sync stage
        logic [7:0] pc_in;                   // Second sync stage
        logic [2:0] ctl;                     // Second stage of control pins
        logic       pwr_prev;                // Previous power line level
        logic       ir_prev;                 // Previous infrared line level
        logic       pwr_flag;                // Power interrupt latch
        logic       ir_flag;                 // Infrared interrupt latch
        logic       restart;                 // Restart pulse
        logic       prog;                    // Programming mode
        tvio_pkg::tvio_mode_t mode;          // Run state
        logic [7:0] pa_out;                  // Registered pin values
        logic [7:0] pa_oe;                   // Registered enables
        logic [7:0] pb_out;
        logic [7:0] pb_oe;
        logic [7:0] pc_out;
        logic [7:0] pc_oe;
        logic [7:0] pa_pu;
        logic [7:0] pb_pu;
        logic [7:0] pc_pu;
    } tvio_state_t;

    tvio_state_t st;                         // Current state
    tvio_state_t next_st;                    // Next state

    // Edge detect used for both interrupt latches
    function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
        edge_hit = rise ? (!prev && cur) : (prev && !cur);
    endfunction

    // ========================================================
    // Next-state logic
    always_comb begin
        logic rst_pin_low;
        logic [7:0] pc_alt;
        rst_pin_low = 1'b0;
        pc_alt      = 8'hFF;
        next_st     = st;
        // Pin inputs pass two flops before use
        next_st.pa_s1  = first_port_lines_i;
        next_st.pb_s1  = second_port_lines_i & tvio_pkg::PB_MASK;
        next_st.pc_s1  = third_port_lines_i;
        next_st.ctl_s1 = {1'b0, test_pin_i, reset_n_pin_i};
        next_st.pa_in  = st.pa_s1;
        next_st.pb_in  = st.pb_s1;
        next_st.pc_in  = st.pc_s1;
        next_st.ctl    = st.ctl_s1;
        rst_pin_low    = !st.ctl[0];
        next_st.restart = 1'b0;
        // Reset sequencing; test level sampled while reset is held
        case (st.mode)
            tvio_pkg::TVIO_RESET: begin
                next_st.prog = st.ctl[1];
                if (!rst_pin_low) begin
                    next_st.mode    = st.ctl[1] ? tvio_pkg::TVIO_PROG : tvio_pkg::TVIO_RUN;
                    next_st.restart = !st.ctl[1];
                end
            end
            tvio_pkg::TVIO_RUN, tvio_pkg::TVIO_PROG: begin
                if (rst_pin_low) begin
                    next_st.mode = tvio_pkg::TVIO_RESET;
                end
            end
            default: next_st.mode = tvio_pkg::TVIO_RESET;
        endcase
        // Serial signals ANDed into third port lines
        pc_alt[tvio_pkg::PC_SCL_BIT] = spi_scl_i;
        pc_alt[tvio_pkg::PC_SDA_BIT] = spi_sda_i;
        pc_alt[tvio_pkg::PC_SEN_BIT] = serial_enable_signal_i;
        // Port drivers; everything released while held in reset
        if (st.mode == tvio_pkg::TVIO_RUN) begin
            // First port: low nibble push-pull, high nibble open-drain
            next_st.pa_out = pa_data_i & ~tvio_pkg::PA_OD_MASK;
            next_st.pa_oe  = pa_dir_i & (~tvio_pkg::PA_OD_MASK | ~pa_data_i);
            next_st.pa_pu  = ~pa_dir_i & pa_pu_i & ~tvio_pkg::PA_OD_MASK;
            next_st.pb_out = pb_data_i & tvio_pkg::PB_MASK;
            next_st.pb_oe  = pb_dir_i & tvio_pkg::PB_MASK;
            next_st.pb_pu  = ~pb_dir_i & pb_pu_i & tvio_pkg::PB_MASK;
            // Third port: all open-drain, driven low only
            next_st.pc_out = 8'h00;
            next_st.pc_oe  = pc_dir_i & ~(pc_data_i & pc_alt);
            next_st.pc_pu  = ~pc_dir_i & pc_pu_i & ~tvio_pkg::PC_NOPU_MASK;
        end else begin
            next_st.pa_out = tvio_pkg::DATA_RST;
            next_st.pa_oe  = tvio_pkg::DIR_RST;
            next_st.pa_pu  = tvio_pkg::PU_RST;
            next_st.pb_out = tvio_pkg::DATA_RST;
            next_st.pb_oe  = tvio_pkg::DIR_RST;
            next_st.pb_pu  = tvio_pkg::PU_RST;
            next_st.pc_out = tvio_pkg::DATA_RST;
            next_st.pc_oe  = tvio_pkg::DIR_RST;
            next_st.pc_pu  = tvio_pkg::PU_RST;
        end
        // Edge latches; set beats clear in the same cycle
        next_st.pwr_prev = st.pc_in[tvio_pkg::PC_PWR_BIT];
        next_st.ir_prev  = st.pc_in[tvio_pkg::PC_IR_BIT];
        if (pwr_clr_i) next_st.pwr_flag = 1'b0;
        if (ir_clr_i) next_st.ir_flag = 1'b0;
        if (st.mode == tvio_pkg::TVIO_RUN &&
            edge_hit(st.pwr_prev, st.pc_in[tvio_pkg::PC_PWR_BIT], pwr_rise_i)) begin
            next_st.pwr_flag = 1'b1;
        end
        if (st.mode == tvio_pkg::TVIO_RUN &&
            edge_hit(st.ir_prev, st.pc_in[tvio_pkg::PC_IR_BIT], ir_rise_i)) begin
            next_st.ir_flag = 1'b1;
        end
    end

    // ========================================================
    // State register with clock enable
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st      <= '0;
            st.ctl  <= 3'h0;
            st.mode <= tvio_pkg::TVIO_RESET;
        end else if (clk_en_i) begin
            st <= next_st;
        end
    end

    // ========================================================
    // Outputs
    assign first_port_lines_o     = st.pa_out;
    assign first_port_lines_oe_o  = st.pa_oe;
    assign first_port_pu_o        = st.pa_pu;
    assign second_port_lines_o    = st.pb_out;
    assign second_port_lines_oe_o = st.pb_oe;
    assign second_port_pu_o       = st.pb_pu;
    assign third_port_lines_o     = st.pc_out;
    assign third_port_lines_oe_o  = st.pc_oe;
    assign third_port_pu_o        = st.pc_pu;
    assign pa_in_o                = st.pa_in;
    assign pb_in_o                = st.pb_in;
    assign pc_in_o                = st.pc_in;
    assign power_interrupt_input_o    = st.pwr_flag;
    assign infrared_interrupt_input_o = st.ir_flag;
    assign core_reset_o = (st.mode == tvio_pkg::TVIO_RESET);
    assign osc_en_o     = (st.mode != tvio_pkg::TVIO_RESET);
    assign restart_o    = st.restart;
    assign prog_mode_o  = st.prog && (st.mode == tvio_pkg::TVIO_PROG);

    // ========================================================
    // Assertions
    a_reset_no_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        core_reset_o |-> (first_port_lines_oe_o == 8'h00 && third_port_lines_oe_o == 8'h00))
        else $error("Port driven during reset");
    a_osc_off_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        osc_en_o != core_reset_o)
        else $error("Oscillator enable wrong");
    a_pa_od_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (first_port_lines_o & tvio_pkg::PA_OD_MASK) == 8'h00)
        else $error("First port upper drives high");
    a_pa_no_pullup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (first_port_pu_o & tvio_pkg::PA_OD_MASK) == 8'h00)
        else $error("First port upper pull-up");
    a_pb_bit3_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !second_port_lines_oe_o[3] && !second_port_pu_o[3])
        else $error("Second port bit 3 active");
    a_pc_open_drain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        third_port_lines_o == 8'h00 && (third_port_pu_o & 8'hF0) == 8'h00)
        else $error("Third port not open-drain");
    a_pc_scl_and: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && st.mode == tvio_pkg::TVIO_RUN && pc_dir_i[0] && !spi_scl_i)
        |=> third_port_lines_oe_o[0])
        else $error("Serial clock not ANDed");
    a_restart_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        // A frozen cycle keeps the pulse up, so only a live edge is judged
        (restart_o && $past(clk_en_i)) |-> $past(core_reset_o) && !core_reset_o && !prog_mode_o)
        else $error("Restart without reset release");
    a_prog_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && core_reset_o && st.ctl[0] && st.ctl[1]) |=> prog_mode_o)
        else $error("Programming mode not entered");
    a_pwr_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && st.mode == tvio_pkg::TVIO_RUN && pwr_rise_i &&
         !st.pwr_prev && st.pc_in[4]) |=> power_interrupt_input_o)
        else $error("Power edge not latched");
    a_pa_pushpull: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && st.mode == tvio_pkg::TVIO_RUN && pa_dir_i[0])
        |=> first_port_lines_oe_o[0])
        else $error("First port output not driven");
    a_pc_pullup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && st.mode == tvio_pkg::TVIO_RUN && !pc_dir_i[2] && pc_pu_i[2])
        |=> third_port_pu_o[2])
        else $error("Third port pull-up missing");
    // Pin release seen while held, normal level on the test pin
    sequence s_pin_release;
        clk_en_i && core_reset_o && st.ctl[0] && !st.ctl[1];
    endsequence
    // Core running, oscillator on, one restart pulse
    sequence s_run_start;
        !core_reset_o && osc_en_o && restart_o;
    endsequence
    a_release_run: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_pin_release |=> s_run_start)
        else $error("Release did not start the core");
endmodule
`default_nettype wire

/* verif/tvio_board.sv */
// Board model: resolves the 24 pin levels of the three ports.
// Assumes bit order {third, second, first}; outside drivers set by the bench.
`timescale 1ns/10ps
`default_nettype none
module tvio_board #(
    parameter logic [23:0] BOARD_PU = 24'hFF00F0 // Resistors on open-drain lines
) (
    input  wire logic        ref_clk_i, // Clock for the float pattern
    input  wire logic [23:0] oe_i,      // Device drive enables
    input  wire logic [23:0] out_i,     // Device drive values
    input  wire logic [23:0] pu_i,      // Device pull-ups
    input  wire logic [23:0] ext_en_i,  // Outside circuit drives
    input  wire logic [23:0] ext_val_i, // Outside circuit values
    output logic      [23:0] pins_o     // Resolved levels
);
    // ============================================================
    // Level resolution
    logic float_q = 1'b0; // Undriven lines wander so no stale value survives
    // Noise source for floating lines
    always @(posedge ref_clk_i) begin
        float_q <= ~float_q;
    end
    // Device first, then outside, then resistors, then noise
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (oe_i[i]) begin
                pins_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                pins_o[i] = ext_val_i[i];
            end else if (pu_i[i] || BOARD_PU[i]) begin
                pins_o[i] = 1'b1;
            end else begin
                pins_o[i] = float_q ^ i[0];
            end
        end
    end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the three-port I/O block with a board model.
// Assumes 40 MHz clock; stimulus at rising edges, checks 1 ns later.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ============================================================
    // Stimulus and observation
    logic        clk, rst, clk_en, rst_n_pin, test_pin, scl, sda, serial_enable_signal;
    logic        pwr_rise, ir_rise, pwr_clr, ir_clr, pwr_f, ir_f, core_rst, restart, osc, prog;
    logic [7:0]  pa_dir, pa_pu, pa_data, pb_dir, pb_pu, pb_data, pc_dir, pc_pu, pc_data;
    logic [7:0]  pa_o, pa_oe, pa_pu_o, pb_o, pb_oe, pb_pu_o, pc_o, pc_oe, pc_pu_o;
    logic [7:0]  pa_in, pb_in, pc_in;
    logic [23:0] ext_en, ext_val, pins;
    int          fail_count, num_checks;
    tvio_ports u_tvio_ports (.ref_clk_i(clk), .rst_i(rst), .clk_en_i(clk_en),
        .reset_n_pin_i(rst_n_pin), .test_pin_i(test_pin), .pa_dir_i(pa_dir), .pa_pu_i(pa_pu),
        .pa_data_i(pa_data), .pb_dir_i(pb_dir), .pb_pu_i(pb_pu), .pb_data_i(pb_data),
        .pc_dir_i(pc_dir), .pc_pu_i(pc_pu), .pc_data_i(pc_data), .spi_scl_i(scl),
        .spi_sda_i(sda), .serial_enable_signal_i(serial_enable_signal), .pwr_rise_i(pwr_rise),
        .ir_rise_i(ir_rise), .pwr_clr_i(pwr_clr), .ir_clr_i(ir_clr),
        .first_port_lines_i(pins[7:0]), .second_port_lines_i(pins[15:8]),
        .third_port_lines_i(pins[23:16]), .first_port_lines_o(pa_o),
        .first_port_lines_oe_o(pa_oe), .first_port_pu_o(pa_pu_o), .second_port_lines_o(pb_o),
        .second_port_lines_oe_o(pb_oe), .second_port_pu_o(pb_pu_o),
        .third_port_lines_o(pc_o), .third_port_lines_oe_o(pc_oe), .third_port_pu_o(pc_pu_o),
        .pa_in_o(pa_in), .pb_in_o(pb_in), .pc_in_o(pc_in), .power_interrupt_input_o(pwr_f),
        .infrared_interrupt_input_o(ir_f), .core_reset_o(core_rst), .restart_o(restart),
        .osc_en_o(osc), .prog_mode_o(prog));
    tvio_board u_tvio_board (.ref_clk_i(clk), .oe_i({pc_oe, pb_oe, pa_oe}),
        .out_i({pc_o, pb_o, pa_o}), .pu_i({pc_pu_o, pb_pu_o, pa_pu_o}), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pins_o(pins));
    // ============================================================
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One comparison kind: bytes, flags zero-extended
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Ports in order dir, pu, data for first, second, third
    task automatic cfg(input logic [71:0] c);
        @(posedge clk);
        {pa_dir, pa_pu, pa_data, pb_dir, pb_pu, pb_data, pc_dir, pc_pu, pc_data} <= c;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ============================================================
    // Scenarios
    // Outputs requested while held: first and third ports may not drive until release
    task automatic t_reset;
        cfg({3{8'hFF, 8'hFF, 8'h00}});
        cyc(3);
        chk8("first oe held", 8'h00, pa_oe);
        chk8("third oe held", 8'h00, pc_oe);
        chk8("osc held", 8'h00, {7'h0, osc});
        chk8("core held", 8'h01, {7'h0, core_rst});
        @(posedge clk);
        rst_n_pin <= 1'b1;
        for (int i = 0; i < 8 && restart !== 1'b1; i++) cyc(1);
        chk8("restart", 8'h01, {7'h0, restart});
        chk8("core run", 8'h00, {7'h0, core_rst});
        cyc(1);
        chk8("restart end", 8'h00, {7'h0, restart});
        chk8("osc run", 8'h01, {7'h0, osc});
    endtask
    // Push-pull low nibble, open-drain high nibble, read back from pins
    task automatic t_first;
        cfg({8'hFF, 8'h00, 8'hA5, 48'h0});
        cyc(4);
        chk8("first oe", 8'h5F, pa_oe);
        chk8("first out", 8'h05, pa_o);
        chk8("first in", 8'hA5, pa_in);
        cfg({8'h00, 8'hFF, 8'h00, 48'h0});
        cyc(2);
        chk8("first pu", 8'h0F, pa_pu_o);
    endtask
    // Missing bit 3 must stay quiet both ways, even with its pin high
    task automatic t_second;
        cfg({24'h0, 8'hFF, 8'h00, 8'hFF, 24'h0});
        cyc(2);
        chk8("second oe", tvio_pkg::PB_MASK, pb_oe);
        chk8("second out", 8'h77, pb_o);
        cfg({24'h0, 8'h00, 8'hFF, 8'h00, 24'h0});
        ext_en <= 24'h00FF00;
        ext_val <= 24'h005A00;
        cyc(4);
        chk8("second pu", 8'h77, pb_pu_o);
        chk8("second in", 8'h52, pb_in);
        @(posedge clk);
        ext_en <= 24'h0;
    endtask
    // Open-drain third port with serial signals gated in
    task automatic t_third;
        logic [18:0] tbl [3] = '{{8'hFF, 3'b010, 8'h09}, {8'hF6, 3'b101, 8'h0B},
                                 {8'h0F, 3'b111, 8'hF0}};
        for (int i = 0; i < 3; i++) begin
            cfg({48'h0, 8'hFF, 8'h00, tbl[i][18:11]});
            {scl, sda, serial_enable_signal} <= tbl[i][10:8];
            cyc(3);
            chk8("third oe", tbl[i][7:0], pc_oe);
            chk8("third out", 8'h00, pc_o);
        end
        cfg({48'h0, 8'h00, 8'hFF, 8'h00});
        cyc(2);
        chk8("third pu", 8'h0F, pc_pu_o);
    endtask
    // Rising latch on line 4, falling latch on line 6, wrong edge ignored
    task automatic t_irq;
        @(posedge clk);
        ext_en <= 24'h500000;
        ext_val <= 24'h400000;
        pwr_clr <= 1'b1;
        ir_clr <= 1'b1;
        cyc(6);
        chk8("third in", 8'hEF, pc_in);
        @(posedge clk);
        {pwr_clr, ir_clr} <= 2'b00;
        ext_val <= 24'h500000;
        cyc(6);
        chk8("power flag", 8'h01, {7'h0, pwr_f});
        chk8("ir quiet", 8'h00, {7'h0, ir_f});
        @(posedge clk);
        ext_val <= 24'h000000;
        pwr_clr <= 1'b1;
        @(posedge clk);
        pwr_clr <= 1'b0;
        cyc(6);
        chk8("power falling", 8'h00, {7'h0, pwr_f});
        chk8("ir flag", 8'h01, {7'h0, ir_f});
    endtask
    // Clock enable low: a new setting must wait until it comes back
    task automatic t_hold;
        cfg({8'hFF, 8'h00, 8'h0F, 48'h0});
        cyc(2);
        chk8("hold before", 8'hFF, pa_oe);
        @(posedge clk);
        clk_en <= 1'b0;
        cfg(72'h0);
        cyc(3);
        chk8("hold frozen", 8'hFF, pa_oe);
        @(posedge clk);
        clk_en <= 1'b1;
        cyc(2);
        chk8("hold resumed", 8'h00, pa_oe);
    endtask
    // Test pin at programming level through reset: no restart, lines released
    task automatic t_prog;
        int seen = 0;
        cfg({8'hFF, 8'h00, 8'h0F, 48'h0});
        {rst, rst_n_pin, test_pin} <= 3'b101;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n_pin <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            seen += int'(restart === 1'b1);
        end
        chk8("prog mode", 8'h01, {7'h0, prog});
        chk8("no restart", 8'h00, 8'(seen));
        chk8("prog oe", 8'h00, pa_oe);
        @(posedge clk);
        test_pin <= 1'b0;
    endtask
    // ============================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 4000);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {rst, clk_en, rst_n_pin, test_pin, scl, sda, serial_enable_signal} = 7'b1100111;
        {pwr_rise, ir_rise, pwr_clr, ir_clr} = 4'b1000;
        {pa_dir, pa_pu, pa_data, pb_dir, pb_pu, pb_data, pc_dir, pc_pu, pc_data} = '0;
        {ext_en, ext_val, fail_count, num_checks} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_first();
        t_second();
        t_third();
        t_irq();
        t_hold();
        t_prog();
        tally_and_finish();
    end
endmodule
`default_nettype wire
